// *** ssc_map.svh ***
// Register offsets, field positions, reset values and timing counts of the safing controller
//
// Contract
// (R1) Start-up mode is entered when the state-machine reset is released.
// (R2) Start-up mode takes no samples and never activates the arming pair.
// (R3) Threshold writes take effect only in start-up mode.
// (R4) First successful watchdog feed moves start-up to diagnostic.
// (R5) Diagnostic test drives both outputs alike; fire high with inhibit low never occurs.
// (R6) Diagnostic ends only on a safety-control command selecting safing or scrap.
// (R7) Safing mode is left only by the state-machine reset.
// (R8) Scrap stops monitoring; exits only by key handshake to arming or reset.
// (R9) Arming mode drives fire-enable high and inhibit low.
// (R10) Seed comes from a free-running 8-bit counter, read by the seed command.
// (R11) Reading the seed freezes it and yields the expected key.
// (R12) Key equals seed XOR 0x55, submitted by the key command.
// (R13) Scrap enters arming only on matching key and valid authorization.
// (R14) Processor resubmits the key with valid authorization before the scrap timeout.
// (R15) Wrong key, timeout or lost authorization returns arming to scrap.
// (R16) Processor requests all sensors in fixed order after each sync rise.
// (R17) Sequence pairs 0000-1101 select thresholds 0-6; 1110 selects threshold 7.
// (R18) Three consecutive over-threshold samples of one sensor set the safing signal.
// (R19) Safing signal asserts the arming pair, extended 255 ms or 2.0 s.
// (R20) Sequence counter advances per response and resets on each sync rise.
// (R21) Sequence mismatch sets the fault bit and disables safing until next sync.
// (R22) Valid-data frames are counted per period, reset on sync, readable.
// (R23) Sequence counter resets to all ones; first sample makes it zero.
// (R24) Threshold MSB selects the dwell extension length.
// (R25) Otherwise fire-enable stays low and inhibit stays high.
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SSC_ADDR_STATUS 5'h00
`define SSC_ADDR_SAFETY_CONTROL_COMMAND 5'h01
`define SSC_ADDR_SEED 5'h02
`define SSC_ADDR_KEY 5'h03
`define SSC_ADDR_THR_BASE 5'h08

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SSC_CTL_LEV_BIT 0
`define SSC_CTL_TEN_BIT 1
`define SSC_CTL_TRANS_LSB 2
`define SSC_TRANS_SAFING 2'h1
`define SSC_TRANS_SCRAP 2'h2
`define SSC_KEY_MASK 8'h55
`define SSC_SEQ_RESET 4'hF
`define SSC_SEQ_LAST 4'hE
`define SSC_THR_DEFAULT 8'h7F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSC_CLK_MHZ 40
`define SSC_DWELL_SHORT_MS 255
`define SSC_DWELL_LONG_MS 2000
`define SSC_SCRAP_TMO_US 600
`define SSC_DWELL_SHORT_CYC (`SSC_DWELL_SHORT_MS * 1000 * `SSC_CLK_MHZ)
`define SSC_DWELL_LONG_CYC (`SSC_DWELL_LONG_MS * 1000 * `SSC_CLK_MHZ)
`define SSC_SCRAP_TMO_CYC (`SSC_SCRAP_TMO_US * `SSC_CLK_MHZ)

`endif

// *** ssc_pkg.sv ***
// Types shared by the safing controller
package ssc_pkg;

   // ----------------------------------------------------------------
   // Sequencer modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SSC_STARTUP = 3'b000,
      SSC_DIAG = 3'b001,
      SSC_SAFING = 3'b010,
      SSC_SCRAP = 3'b011,
      SSC_ARMING = 3'b100
   } ssc_mode_t;

   // ----------------------------------------------------------------
   // One decoded sensor response from the monitor
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [2:0] seq_id;
      logic data_ok;
      logic [9:0] sample;
   } ssc_resp_t;

endpackage

// *** ssc_safing_ctrl.sv ***
// Safing state controller: mode sequencer, safing compare, seed/key arming handshake
//
// Implementation choices: the plain strobed port and the placing of the registers.
`include "ssc_map.svh"

module ssc_safing_ctrl #(
   parameter int DWELL_SHORT_CYC = `SSC_DWELL_SHORT_CYC,
   parameter int DWELL_LONG_CYC = `SSC_DWELL_LONG_CYC,
   parameter int SCRAP_TMO_CYC = `SSC_SCRAP_TMO_CYC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic wdog_feed_ok,
   input wire ssc_pkg::ssc_resp_t sensor_resp,
   input wire logic sample_sync,
   input wire logic authorization_signal,
   output logic fire_enable,
   output logic inhibit_output_n,
   output logic [2:0] mode_out
);

   localparam int DW = 27;
   localparam int TW = 16;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Sequence pairs share a threshold; 1110 lands on 7 by the same shift
   function automatic logic [2:0] thr_index(input logic [3:0] seq);
      thr_index = seq[3:1];
   endfunction

   // Threshold low bits scaled onto the signed 10-bit sample range
   function automatic logic over_thr(input logic [9:0] s, input logic [7:0] t);
      over_thr = $signed(s) > $signed({1'b0, t[6:0], 2'b00});
   endfunction

   ssc_pkg::ssc_mode_t mode_ff;
   logic [2:0] sync_ff;
   logic sync_lvl_ff;
   logic sync_rise_ff;
   logic [2:0] auth_ff;
   logic auth_lvl_ff;
   logic [7:0] thr_ff [8];
   logic [7:0] seed_cnt_ff;
   logic [7:0] seed_ff;
   logic seed_frozen_ff;
   logic [3:0] seq_cnt_ff;
   logic [3:0] valid_cnt_ff;
   logic seq_fault_ff;
   logic seq_dis_ff;
   logic [1:0] hit_ff [15];
   logic dwell_sel_ff;
   logic [DW-1:0] dwell_ff;
   logic [TW-1:0] tmo_ff;
   logic diag_ten_ff;
   logic diag_lev_ff;
   logic fire_ff;
   logic inhibit_n_ff;
   logic [7:0] rdata_ff;

   logic wr_ctl, wr_key, rd_seed, rd_ctl, key_ok;
   logic [1:0] trans;
   logic resp_take, mismatch, cmp_en, safing_act;
   logic [3:0] nxt_seq;

   assign wr_ctl = reg_wr && reg_addr == `SSC_ADDR_SAFETY_CONTROL_COMMAND;
   assign wr_key = reg_wr && reg_addr == `SSC_ADDR_KEY;
   assign rd_seed = reg_rd && reg_addr == `SSC_ADDR_SEED;
   assign rd_ctl = reg_rd && reg_addr == `SSC_ADDR_STATUS;
   assign trans = reg_wdata[`SSC_CTL_TRANS_LSB +: 2];
   // A key never counts before a seed was frozen
   assign key_ok = seed_frozen_ff && reg_wdata == (seed_ff ^ `SSC_KEY_MASK); // see (R12)

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Level accepted only when stages two and three agree
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync_ff <= 3'h0;
         sync_lvl_ff <= 1'b0;
         sync_rise_ff <= 1'b0;
         auth_ff <= 3'h0;
         auth_lvl_ff <= 1'b0;
      end else begin
         sync_ff <= {sync_ff[1:0], sample_sync};
         auth_ff <= {auth_ff[1:0], authorization_signal};
         sync_rise_ff <= 1'b0;
         if (sync_ff[1] == sync_ff[2]) begin
            sync_lvl_ff <= sync_ff[2];
            sync_rise_ff <= sync_ff[2] && !sync_lvl_ff;
         end
         if (auth_ff[1] == auth_ff[2]) begin
            auth_lvl_ff <= auth_ff[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------
   // Reset is the single way back to start-up, from any mode
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mode_ff <= ssc_pkg::SSC_STARTUP; // see (R1) (R7)
         tmo_ff <= '0;
      end else begin
         case (mode_ff)
            ssc_pkg::SSC_STARTUP: begin
               if (wdog_feed_ok) begin
                  mode_ff <= ssc_pkg::SSC_DIAG; // see (R4)
               end
            end
            ssc_pkg::SSC_DIAG: begin
               if (wr_ctl && trans == `SSC_TRANS_SAFING) begin
                  mode_ff <= ssc_pkg::SSC_SAFING; // see (R6)
               end else if (wr_ctl && trans == `SSC_TRANS_SCRAP) begin
                  mode_ff <= ssc_pkg::SSC_SCRAP; // see (R6)
               end
            end
            ssc_pkg::SSC_SAFING: begin
               mode_ff <= ssc_pkg::SSC_SAFING; // see (R7)
            end
            ssc_pkg::SSC_SCRAP: begin
               if (wr_key && key_ok && auth_lvl_ff) begin
                  mode_ff <= ssc_pkg::SSC_ARMING; // see (R8) (R13)
                  tmo_ff <= TW'(SCRAP_TMO_CYC);
               end
            end
            ssc_pkg::SSC_ARMING: begin
               if (!auth_lvl_ff || tmo_ff == '0 || (wr_key && !key_ok)) begin
                  mode_ff <= ssc_pkg::SSC_SCRAP; // see (R15)
               end else if (wr_key) begin
                  tmo_ff <= TW'(SCRAP_TMO_CYC); // see (R14)
               end else begin
                  tmo_ff <= tmo_ff - 1'b1;
               end
            end
            default: begin
               mode_ff <= ssc_pkg::SSC_STARTUP;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Seed generator and freeze
   // ----------------------------------------------------------------
   // Counter runs every cycle so the seed is hard to predict
   always_ff @(posedge core_clk) begin
      if (srst) begin
         seed_cnt_ff <= 8'h00;
         seed_ff <= 8'h00;
         seed_frozen_ff <= 1'b0;
      end else begin
         seed_cnt_ff <= seed_cnt_ff + 8'h01; // see (R10)
         if (rd_seed) begin
            seed_ff <= seed_cnt_ff; // see (R11)
            seed_frozen_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Thresholds and diagnostic test levels
   // ----------------------------------------------------------------
   // Writes outside start-up are dropped silently
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int i = 0; i < 8; i++) begin
            thr_ff[i] <= `SSC_THR_DEFAULT;
         end
      end else if (reg_wr && mode_ff == ssc_pkg::SSC_STARTUP && reg_addr[4:3] == 2'h1) begin
         thr_ff[reg_addr[2:0]] <= reg_wdata; // see (R3)
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         diag_ten_ff <= 1'b0;
         diag_lev_ff <= 1'b0;
      end else if (wr_ctl && mode_ff == ssc_pkg::SSC_DIAG) begin
         diag_ten_ff <= reg_wdata[`SSC_CTL_TEN_BIT];
         diag_lev_ff <= reg_wdata[`SSC_CTL_LEV_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Sequence and valid-data counters
   // ----------------------------------------------------------------
   // Monitoring happens in safing mode only; frozen at 1110
   assign resp_take = sensor_resp.valid && mode_ff == ssc_pkg::SSC_SAFING && seq_cnt_ff != `SSC_SEQ_LAST; // see (R2) (R8)
   assign nxt_seq = seq_cnt_ff + 4'h1;
   assign mismatch = resp_take && sensor_resp.seq_id != nxt_seq[2:0];
   assign cmp_en = resp_take && !mismatch && !seq_dis_ff && sensor_resp.data_ok;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         seq_cnt_ff <= `SSC_SEQ_RESET; // see (R23)
         valid_cnt_ff <= 4'h0;
         seq_dis_ff <= 1'b0;
      end else if (sync_rise_ff) begin
         seq_cnt_ff <= `SSC_SEQ_RESET; // see (R20) (R23)
         valid_cnt_ff <= 4'h0; // see (R22)
         seq_dis_ff <= 1'b0; // see (R21)
      end else begin
         if (resp_take) begin
            seq_cnt_ff <= nxt_seq; // see (R20)
         end
         if (cmp_en) begin
            valid_cnt_ff <= valid_cnt_ff + 4'h1; // see (R22)
         end
         if (mismatch) begin
            seq_dis_ff <= 1'b1; // see (R21)
         end
      end
   end

   // Fault bit clears on status read, but a new mismatch wins
   always_ff @(posedge core_clk) begin
      if (srst) begin
         seq_fault_ff <= 1'b0;
      end else if (mismatch) begin
         seq_fault_ff <= 1'b1; // see (R21)
      end else if (rd_ctl) begin
         seq_fault_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Safing compare and dwell extension
   // ----------------------------------------------------------------
   // Each sequence slot keeps its own run of over-threshold samples
   always_ff @(posedge core_clk) begin
      if (srst || mode_ff != ssc_pkg::SSC_SAFING) begin
         for (int i = 0; i < 15; i++) begin
            hit_ff[i] <= 2'h0;
         end
         dwell_sel_ff <= 1'b0;
      end else if (cmp_en) begin
         if (over_thr(sensor_resp.sample, thr_ff[thr_index(nxt_seq)])) begin // see (R17)
            if (hit_ff[nxt_seq] != 2'h3) begin
               hit_ff[nxt_seq] <= hit_ff[nxt_seq] + 2'h1; // see (R18)
            end
            if (hit_ff[nxt_seq] == 2'h2) begin
               dwell_sel_ff <= thr_ff[thr_index(nxt_seq)][7]; // see (R24)
            end
         end else begin
            hit_ff[nxt_seq] <= 2'h0; // see (R18)
         end
      end
   end

   always_comb begin
      safing_act = 1'b0;
      for (int i = 0; i < 15; i++) begin
         safing_act = safing_act | (hit_ff[i] == 2'h3);
      end
   end

   // Dwell reloads while safing holds, then runs down
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dwell_ff <= '0;
      end else if (safing_act) begin
         dwell_ff <= dwell_sel_ff ? DW'(DWELL_LONG_CYC) : DW'(DWELL_SHORT_CYC); // see (R19) (R24)
      end else if (dwell_ff != '0) begin
         dwell_ff <= dwell_ff - 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Arming output pair
   // ----------------------------------------------------------------
   // Registered so the pins never glitch on decode
   always_ff @(posedge core_clk) begin
      if (srst) begin
         fire_ff <= 1'b0; // see (R25)
         inhibit_n_ff <= 1'b1;
      end else begin
         case (mode_ff)
            ssc_pkg::SSC_ARMING: begin
               fire_ff <= 1'b1; // see (R9)
               inhibit_n_ff <= 1'b0;
            end
            ssc_pkg::SSC_SAFING: begin
               fire_ff <= safing_act || dwell_ff != '0; // see (R19)
               inhibit_n_ff <= !(safing_act || dwell_ff != '0);
            end
            ssc_pkg::SSC_DIAG: begin
               // With the test enabled both outputs follow one level, so the firing pair cannot form
               fire_ff <= diag_ten_ff && diag_lev_ff; // see (R5)
               inhibit_n_ff <= !diag_ten_ff || diag_lev_ff; // see (R5)
            end
            default: begin
               fire_ff <= 1'b0; // see (R2) (R25)
               inhibit_n_ff <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `SSC_ADDR_STATUS: rdata_ff <= {valid_cnt_ff, mode_ff == ssc_pkg::SSC_ARMING, seq_dis_ff,
                                           fire_ff, seq_fault_ff}; // see (R22)
            `SSC_ADDR_SAFETY_CONTROL_COMMAND: rdata_ff <= {1'b0, mode_ff, 2'h0, diag_ten_ff, diag_lev_ff};
            `SSC_ADDR_SEED: rdata_ff <= seed_cnt_ff; // see (R10) (R11)
            default: begin
               if (reg_addr[4:3] == 2'h1) begin
                  rdata_ff <= thr_ff[reg_addr[2:0]];
               end else begin
                  rdata_ff <= 8'h00;
               end
            end
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata = rdata_ff;
   assign fire_enable = fire_ff;
   assign inhibit_output_n = inhibit_n_ff;
   assign mode_out = mode_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_reset_startup;
      @(posedge core_clk) srst |=> mode_ff == ssc_pkg::SSC_STARTUP;
   endproperty
   a_reset_startup: assert property (p_reset_startup) else $error("mode not start-up after reset"); // see (R1)

   property p_startup_quiet;
      @(posedge core_clk) disable iff (srst)
         mode_ff == ssc_pkg::SSC_STARTUP ##1 mode_ff == ssc_pkg::SSC_STARTUP |-> !fire_ff && inhibit_n_ff;
   endproperty
   a_startup_quiet: assert property (p_startup_quiet) else $error("arming pair active in start-up"); // see (R2)

   property p_thr_locked;
      @(posedge core_clk) disable iff (srst)
         mode_ff != ssc_pkg::SSC_STARTUP |=> $stable(thr_ff[0]) && $stable(thr_ff[1]) && $stable(thr_ff[7]);
   endproperty
   a_thr_locked: assert property (p_thr_locked) else $error("threshold changed outside start-up"); // see (R3)

   property p_feed_diag;
      @(posedge core_clk) disable iff (srst)
         mode_ff == ssc_pkg::SSC_STARTUP && wdog_feed_ok |=> mode_ff == ssc_pkg::SSC_DIAG;
   endproperty
   a_feed_diag: assert property (p_feed_diag) else $error("feed did not enter diagnostic"); // see (R4)

   property p_no_fire_pair;
      @(posedge core_clk) disable iff (srst)
         mode_ff == ssc_pkg::SSC_DIAG ##1 mode_ff == ssc_pkg::SSC_DIAG |-> !(fire_ff && !inhibit_n_ff);
   endproperty
   a_no_fire_pair: assert property (p_no_fire_pair) else $error("firing pair in diagnostic"); // see (R5)

   property p_safing_sticky;
      @(posedge core_clk) disable iff (srst)
         mode_ff == ssc_pkg::SSC_SAFING |=> mode_ff == ssc_pkg::SSC_SAFING;
   endproperty
   a_safing_sticky: assert property (p_safing_sticky) else $error("left safing without reset"); // see (R7)

   property p_arm_outputs;
      @(posedge core_clk) disable iff (srst)
         mode_ff == ssc_pkg::SSC_ARMING ##1 mode_ff == ssc_pkg::SSC_ARMING |-> fire_ff && !inhibit_n_ff;
   endproperty
   a_arm_outputs: assert property (p_arm_outputs) else $error("arming mode without outputs"); // see (R9)

   property p_arm_entry;
      @(posedge core_clk) disable iff (srst)
         $rose(mode_ff == ssc_pkg::SSC_ARMING) |-> $past(wr_key) && $past(key_ok) && $past(auth_lvl_ff);
   endproperty
   a_arm_entry: assert property (p_arm_entry) else $error("arming entered without handshake"); // see (R13)

   property p_bad_key_exit;
      @(posedge core_clk) disable iff (srst)
         mode_ff == ssc_pkg::SSC_ARMING && (!auth_lvl_ff || (wr_key && !key_ok))
         |=> mode_ff == ssc_pkg::SSC_SCRAP ##1 !fire_ff;
   endproperty
   a_bad_key_exit: assert property (p_bad_key_exit) else $error("arming kept after fault"); // see (R15)

   property p_fault_set;
      @(posedge core_clk) disable iff (srst)
         mismatch && !sync_rise_ff |=> seq_fault_ff && seq_dis_ff;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("mismatch did not flag fault"); // see (R21)

   property p_sync_clear;
      @(posedge core_clk) disable iff (srst)
         sync_rise_ff |=> seq_cnt_ff == `SSC_SEQ_RESET && valid_cnt_ff == 4'h0;
   endproperty
   a_sync_clear: assert property (p_sync_clear) else $error("sync did not reset counters"); // see (R20) (R23)

   c_enter_arming: cover property (@(posedge core_clk) $rose(mode_ff == ssc_pkg::SSC_ARMING));
   c_safing_fire: cover property (@(posedge core_clk) mode_ff == ssc_pkg::SSC_SAFING && safing_act);
   c_seq_fault: cover property (@(posedge core_clk) mismatch);
   c_arm_timeout: cover property (@(posedge core_clk) mode_ff == ssc_pkg::SSC_ARMING && tmo_ff == '0);

endmodule

// *** ssc_mcu_model.sv ***
// Processor model that opens sample periods and returns decoded sensor responses
module ssc_mcu_model (
   input wire logic core_clk,
   output logic sample_sync,
   output ssc_pkg::ssc_resp_t sensor_resp
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Idle state
   // ------------------------------------------------------------
   initial begin
      sample_sync = 1'b0;
      sensor_resp = '0;
   end

   // ------------------------------------------------------------
   // One sample period: sync rise, then all 15 sensors in fixed order
   // ------------------------------------------------------------
   // Sync is held long enough to pass the pin synchroniser.
   // Between responses the sample lines flip, so stale data is never read as fresh.
   task automatic period(input logic bad_first, input logic [9:0] smp);
      int i;
      @(posedge core_clk);
      sample_sync <= 1'b1;
      repeat (6) @(posedge core_clk);
      sample_sync <= 1'b0;
      for (i = 0; i < 15; i++) begin
         @(posedge core_clk);
         sensor_resp <= '{1'b1, i[2:0] ^ {2'b00, bad_first && i == 0}, 1'b1, smp};
         @(posedge core_clk);
         sensor_resp <= '{1'b0, 3'h0, 1'b0, ~smp};
      end
      repeat (3) @(posedge core_clk);
   endtask
endmodule

// *** ssc_safing_ctrl_tb.sv ***
// Self-checking bench for the safing state controller
`include "ssc_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end

module ssc_safing_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, wdog_feed_ok = 1'b0;
   logic authorization_signal = 1'b0, sample_sync, fire_enable, inhibit_output_n;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd, seed;
   logic [2:0] mode_out;
   ssc_pkg::ssc_resp_t sensor_resp;
   int err_total = 0, n_tests = 0, cyc = 0;

   ssc_safing_ctrl #(.DWELL_SHORT_CYC(20), .DWELL_LONG_CYC(40), .SCRAP_TMO_CYC(50)) i_dut (
      .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdog_feed_ok(wdog_feed_ok), .sensor_resp(sensor_resp),
      .sample_sync(sample_sync), .authorization_signal(authorization_signal), .fire_enable(fire_enable),
      .inhibit_output_n(inhibit_output_n), .mode_out(mode_out));
   ssc_mcu_model i_mcu (.core_clk(core_clk), .sample_sync(sample_sync), .sensor_resp(sensor_resp));

   // ------------------------------------------------------------
   // Clock, hang guard and verdict
   // ------------------------------------------------------------
   initial forever #12.5 core_clk = ~core_clk;
   // Whole run needs well under 3000 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Bus and check helpers
   // ------------------------------------------------------------
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdr(input logic [4:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      rd = reg_rdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic chk_out(input logic [2:0] m, input logic f, input logic i);
      `CHK("mode", m, mode_out)
      `CHK("fire", f, fire_enable)
      `CHK("inhibit_n", i, inhibit_output_n)
   endtask
   task automatic reset();
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
   endtask
   task automatic feed();
      @(posedge core_clk);
      wdog_feed_ok <= 1'b1;
      @(posedge core_clk);
      wdog_feed_ok <= 1'b0;
      tick(2);
   endtask
   // Seed read freezes the value; the matching key is seed with even bits flipped
   task automatic arm();
      rdr(`SSC_ADDR_SEED);
      seed = rd;
      wr(`SSC_ADDR_KEY, seed ^ `SSC_KEY_MASK);
      tick(2);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      authorization_signal <= 1'b1;
      tick(1);
      chk_out(ssc_pkg::SSC_STARTUP, 1'b0, 1'b1);
      rdr(`SSC_ADDR_THR_BASE + 5'h01);
      `CHK("thr1 default", `SSC_THR_DEFAULT, rd)
      // Top bit picks the long dwell for threshold 0
      wr(`SSC_ADDR_THR_BASE, 8'h85);
      rdr(`SSC_ADDR_THR_BASE);
      `CHK("thr0 write", 8'h85, rd)
      rdr(5'h1F);
      `CHK("unmapped", 8'h00, rd)
      i_mcu.period(1'b0, 10'h064);
      rdr(`SSC_ADDR_STATUS);
      `CHK("startup count", 4'h0, rd[7:4])
      chk_out(ssc_pkg::SSC_STARTUP, 1'b0, 1'b1);
      feed();
      chk_out(ssc_pkg::SSC_DIAG, 1'b0, 1'b1);
      wr(`SSC_ADDR_THR_BASE + 5'h01, 8'h01);
      rdr(`SSC_ADDR_THR_BASE + 5'h01);
      `CHK("thr1 locked", `SSC_THR_DEFAULT, rd)
      wr(`SSC_ADDR_SAFETY_CONTROL_COMMAND, 8'h03);
      tick(2);
      chk_out(ssc_pkg::SSC_DIAG, 1'b1, 1'b1);
      wr(`SSC_ADDR_SAFETY_CONTROL_COMMAND, 8'h02);
      tick(2);
      chk_out(ssc_pkg::SSC_DIAG, 1'b0, 1'b0);
      wr(`SSC_ADDR_SAFETY_CONTROL_COMMAND, 8'h04);
      tick(2);
      chk_out(ssc_pkg::SSC_SAFING, 1'b0, 1'b1);
      // Sample 100 beats threshold 0 (20) only; slots 0 and 1 share it
      repeat (2) i_mcu.period(1'b0, 10'h064);
      chk_out(ssc_pkg::SSC_SAFING, 1'b0, 1'b1);
      i_mcu.period(1'b0, 10'h064);
      rdr(`SSC_ADDR_STATUS);
      `CHK("valid count", 4'hF, rd[7:4])
      chk_out(ssc_pkg::SSC_SAFING, 1'b1, 1'b0);
      // Safing clears early in this period; the long dwell still holds the pair
      i_mcu.period(1'b0, 10'h000);
      tick(1);
      chk_out(ssc_pkg::SSC_SAFING, 1'b1, 1'b0);
      tick(15);
      chk_out(ssc_pkg::SSC_SAFING, 1'b0, 1'b1);
      i_mcu.period(1'b1, 10'h064);
      rdr(`SSC_ADDR_STATUS);
      `CHK("seq fault", 1'b1, rd[0])
      `CHK("seq disabled", 1'b1, rd[2])
      rdr(`SSC_ADDR_STATUS);
      `CHK("fault cleared", 1'b0, rd[0])
      chk_out(ssc_pkg::SSC_SAFING, 1'b0, 1'b1);
      reset();
      tick(1);
      chk_out(ssc_pkg::SSC_STARTUP, 1'b0, 1'b1);
      feed();
      wr(`SSC_ADDR_SAFETY_CONTROL_COMMAND, 8'h08);
      tick(2);
      chk_out(ssc_pkg::SSC_SCRAP, 1'b0, 1'b1);
      i_mcu.period(1'b0, 10'h064);
      rdr(`SSC_ADDR_STATUS);
      `CHK("scrap count", 4'h0, rd[7:4])
      arm();
      chk_out(ssc_pkg::SSC_ARMING, 1'b1, 1'b0);
      tick(30);
      wr(`SSC_ADDR_KEY, seed ^ `SSC_KEY_MASK);
      tick(30);
      chk_out(ssc_pkg::SSC_ARMING, 1'b1, 1'b0);
      wr(`SSC_ADDR_KEY, ~(seed ^ `SSC_KEY_MASK));
      tick(2);
      chk_out(ssc_pkg::SSC_SCRAP, 1'b0, 1'b1);
      arm();
      tick(60);
      chk_out(ssc_pkg::SSC_SCRAP, 1'b0, 1'b1);
      arm();
      @(posedge core_clk);
      authorization_signal <= 1'b0;
      tick(10);
      chk_out(ssc_pkg::SSC_SCRAP, 1'b0, 1'b1);
      arm();
      chk_out(ssc_pkg::SSC_SCRAP, 1'b0, 1'b1);
      give_verdict();
   end
endmodule
